// ### pkg/cpuba_pkg.sv
// Constants and types shared by the branch and addressing core
package cpuba_pkg;

  // Special function register addresses
  localparam logic [7:0] SFR_STACK_POINTER    = 8'h81;
  localparam logic [7:0] SFR_DATA_PTR_LOW     = 8'h82;
  localparam logic [7:0] SFR_DATA_PTR_HIGH    = 8'h83;
  localparam logic [7:0] SFR_CODE_STORE_CTRL  = 8'h8f;
  localparam logic [7:0] SFR_STATUS_WORD      = 8'hd0;
  localparam logic [7:0] SFR_ARITH_MAIN       = 8'he0;
  localparam logic [7:0] SFR_MUL_DIV_AUX      = 8'hf0;

  // Reset values
  localparam logic [7:0]  RST_STACK_POINTER   = 8'h07;
  localparam logic [7:0]  RST_DATA_PTR        = 8'h00;
  localparam logic [7:0]  RST_CODE_STORE_CTRL = 8'h00;
  localparam logic [7:0]  RST_STATUS_WORD     = 8'h00;
  localparam logic [7:0]  RST_ARITH_MAIN      = 8'h00;
  localparam logic [7:0]  RST_MUL_DIV_AUX     = 8'h00;
  localparam logic [15:0] RST_PC              = 16'h0000;

  // Field positions
  localparam int unsigned CARRY_POS       = 7;
  localparam int unsigned BANK_HIGH_POS   = 4;
  localparam int unsigned BANK_LOW_POS    = 3;
  localparam int unsigned CODE_WR_EN_POS  = 0;
  localparam int unsigned SFR_SPACE_POS   = 7;

  // Memory map
  localparam logic [7:0]  BIT_AREA_BASE   = 8'h20;
  localparam logic [15:0] CODE_TOP        = 16'h3dff;

  // Opcodes decoded exactly
  localparam logic [7:0] OP_NOP           = 8'h00;
  localparam logic [7:0] OP_SPARE         = 8'ha5;
  localparam logic [7:0] OP_SHORT_JUMP    = 8'h80;
  localparam logic [7:0] OP_INDEX_JUMP    = 8'h73;
  localparam logic [7:0] OP_CARRY_SET_JMP = 8'h40;
  localparam logic [7:0] OP_CARRY_CLR_JMP = 8'h50;
  localparam logic [7:0] OP_BIT_SET_JMP   = 8'h20;
  localparam logic [7:0] OP_BIT_CLR_JMP   = 8'h30;
  localparam logic [7:0] OP_BIT_SETCLR    = 8'h10;
  localparam logic [7:0] OP_AND_NOT_BIT   = 8'hb0;
  localparam logic [7:0] OP_OR_NOT_BIT    = 8'ha0;
  localparam logic [7:0] OP_SET_BIT       = 8'hd2;
  localparam logic [7:0] OP_CLR_BIT       = 8'hc2;
  localparam logic [7:0] OP_PUSH          = 8'hc0;
  localparam logic [7:0] OP_MOV_DIR_IMM   = 8'h75;
  localparam logic [7:0] OP_EXT_MOVE_WR   = 8'hf0;
  // Opcode families decoded by field
  localparam logic [4:0] OPF_PAGE_JUMP    = 5'h01;
  localparam logic [4:0] OPF_PAGE_CALL    = 5'h11;
  localparam logic [4:0] OPF_DEC_JUMP     = 5'h1b;
  localparam logic [6:0] OPF_CMP_IND      = 7'h5b;
  localparam logic [6:0] OPF_MOV_IND_IMM  = 7'h3b;

  // Lengths in bytes and cycle counts (not taken count where two apply)
  localparam logic [2:0] LEN_1 = 3'd1;
  localparam logic [2:0] LEN_2 = 3'd2;
  localparam logic [2:0] LEN_3 = 3'd3;
  localparam logic [2:0] CYC_1 = 3'd1;
  localparam logic [2:0] CYC_2 = 3'd2;
  localparam logic [2:0] CYC_3 = 3'd3;
  localparam logic [2:0] CYC_4 = 3'd4;

  typedef enum logic [4:0] {
    CL_NOP, CL_PAGE_JUMP, CL_PAGE_CALL, CL_SHORT_JUMP, CL_INDEX_JUMP,
    CL_CARRY_SET_JMP, CL_CARRY_CLR_JMP, CL_BIT_SET_JMP, CL_BIT_CLR_JMP,
    CL_BIT_SETCLR, CL_CMP_IND, CL_DEC_JUMP, CL_AND_NOT_BIT, CL_OR_NOT_BIT,
    CL_SET_BIT, CL_CLR_BIT, CL_PUSH, CL_MOV_DIR_IMM, CL_MOV_IND_IMM, CL_EXT_MOVE
  } cpuba_cls_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } cpuba_ram_wr_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } cpuba_ext_wr_t;

endpackage

// ### design/cpuba_data_ram.sv
// Internal 256-byte data RAM with two reads and two writes
module cpuba_data_ram (
  input  wire logic                     sys_clk,
  input  wire logic [7:0]               rd_a_addr,
  input  wire logic [7:0]               rd_b_addr,
  output logic [7:0]                    rd_a_data,
  output logic [7:0]                    rd_b_data,
  input  wire cpuba_pkg::cpuba_ram_wr_t wr_a,
  input  wire cpuba_pkg::cpuba_ram_wr_t wr_b
);

  logic [7:0] mem [256];

  assign rd_a_data = mem[rd_a_addr];
  assign rd_b_data = mem[rd_b_addr];

  // Port b wins if both hit one byte
  always_ff @(posedge sys_clk) begin
    if (wr_a.en) begin
      mem[wr_a.addr] <= wr_a.data;
    end
    if (wr_b.en) begin
      mem[wr_b.addr] <= wr_b.data;
    end
  end

endmodule

// ### design/cpuba_core.sv
// Branch, bit and data addressing execution core
module cpuba_core (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic [7:0]           code_rdata,
  output logic [15:0]               code_addr_ff,
  output cpuba_pkg::cpuba_ext_wr_t  code_wr_ff,
  output cpuba_pkg::cpuba_ext_wr_t  xdata_wr_ff,
  output logic                      retire_ff,
  output logic                      branch_taken_ff,
  output logic                      reserved_ff,
  output logic [7:0]                stack_pointer_ff,
  output logic [7:0]                status_word_ff
);

  logic [15:0]           pc_ff;
  logic [2:0]            step_ff;
  logic [7:0]            op_ff;
  logic [7:0]            b1_ff;
  logic [7:0]            b2_ff;
  logic [7:0]            data_pointer_low_ff;
  logic [7:0]            data_pointer_high_ff;
  logic [7:0]            arith_main_operand_ff;
  logic [7:0]            mul_div_aux_operand_ff;
  logic [7:0]            code_store_control_ff;

  cpuba_pkg::cpuba_cls_t cls;
  logic [2:0]            len;
  logic [2:0]            base;
  logic                  cond;
  logic                  taken;
  logic [15:0]           nxt_pc;

  wire [7:0]             cur_op;
  wire [7:0]             byte1;
  wire [7:0]             byte2;
  wire                   is_page_jump;
  wire                   is_page_call;
  wire                   is_dec_jump;
  wire                   is_cmp_ind;
  wire                   is_mov_ind;
  wire [7:0]             bank_base;
  wire [7:0]             rn_addr;
  wire [7:0]             ri_addr;
  wire [7:0]             bit_byte;
  wire [2:0]             bit_pos;
  wire [7:0]             bit_mask;
  wire                   is_bit_op;
  wire                   is_ind;
  wire [7:0]             dir_addr;
  wire [7:0]             rd_a_addr;
  wire [7:0]             rd_b_addr;
  wire [7:0]             rd_a_data;
  wire [7:0]             rd_b_data;
  wire [7:0]             sfr_val;
  wire [7:0]             dir_val;
  wire                   bit_val;
  wire                   carry;
  wire [7:0]             dec_val;
  wire [7:0]             rel_byte;
  wire [15:0]            seq_pc;
  wire [15:0]            rel_pc;
  wire [15:0]            page_pc;
  wire [15:0]            index_pc;
  wire [15:0]            data_ptr;
  wire                   last;
  wire                   dir_wr_en;
  wire [7:0]             dir_wr_val;
  wire                   sfr_we;
  wire                   ext_go;
  wire                   code_sel;
  wire                   code_bad;
  wire                   is_call;
  wire                   is_push;
  wire [7:0]             sp_inc1;
  wire [7:0]             sp_inc2;
  cpuba_pkg::cpuba_ram_wr_t ram_wa;
  cpuba_pkg::cpuba_ram_wr_t ram_wb;

  // Opcode byte is live on the bus in step 0, later bytes in their own step
  assign cur_op = (step_ff == 3'd0) ? code_rdata : op_ff;
  assign byte1  = (step_ff == 3'd1) ? code_rdata : b1_ff;
  assign byte2  = (step_ff == 3'd2) ? code_rdata : b2_ff;

  assign is_page_jump = cur_op[4:0] == cpuba_pkg::OPF_PAGE_JUMP;
  assign is_page_call = cur_op[4:0] == cpuba_pkg::OPF_PAGE_CALL;
  assign is_dec_jump  = cur_op[7:3] == cpuba_pkg::OPF_DEC_JUMP;
  assign is_cmp_ind   = cur_op[7:1] == cpuba_pkg::OPF_CMP_IND;
  assign is_mov_ind   = cur_op[7:1] == cpuba_pkg::OPF_MOV_IND_IMM;

  always_comb begin
    cls = cpuba_pkg::CL_NOP;
    if (is_page_jump) begin
      cls = cpuba_pkg::CL_PAGE_JUMP;
    end else if (is_page_call) begin
      cls = cpuba_pkg::CL_PAGE_CALL;
    end else if (is_dec_jump) begin
      cls = cpuba_pkg::CL_DEC_JUMP;
    end else if (is_cmp_ind) begin
      cls = cpuba_pkg::CL_CMP_IND;
    end else if (is_mov_ind) begin
      cls = cpuba_pkg::CL_MOV_IND_IMM;
    end else begin
      case (cur_op)
        cpuba_pkg::OP_NOP:           cls = cpuba_pkg::CL_NOP;
        cpuba_pkg::OP_SPARE:         cls = cpuba_pkg::CL_NOP;
        cpuba_pkg::OP_SHORT_JUMP:    cls = cpuba_pkg::CL_SHORT_JUMP;
        cpuba_pkg::OP_INDEX_JUMP:    cls = cpuba_pkg::CL_INDEX_JUMP;
        cpuba_pkg::OP_CARRY_SET_JMP: cls = cpuba_pkg::CL_CARRY_SET_JMP;
        cpuba_pkg::OP_CARRY_CLR_JMP: cls = cpuba_pkg::CL_CARRY_CLR_JMP;
        cpuba_pkg::OP_BIT_SET_JMP:   cls = cpuba_pkg::CL_BIT_SET_JMP;
        cpuba_pkg::OP_BIT_CLR_JMP:   cls = cpuba_pkg::CL_BIT_CLR_JMP;
        cpuba_pkg::OP_BIT_SETCLR:    cls = cpuba_pkg::CL_BIT_SETCLR;
        cpuba_pkg::OP_AND_NOT_BIT:   cls = cpuba_pkg::CL_AND_NOT_BIT;
        cpuba_pkg::OP_OR_NOT_BIT:    cls = cpuba_pkg::CL_OR_NOT_BIT;
        cpuba_pkg::OP_SET_BIT:       cls = cpuba_pkg::CL_SET_BIT;
        cpuba_pkg::OP_CLR_BIT:       cls = cpuba_pkg::CL_CLR_BIT;
        cpuba_pkg::OP_PUSH:          cls = cpuba_pkg::CL_PUSH;
        cpuba_pkg::OP_MOV_DIR_IMM:   cls = cpuba_pkg::CL_MOV_DIR_IMM;
        cpuba_pkg::OP_EXT_MOVE_WR:   cls = cpuba_pkg::CL_EXT_MOVE;
        default:                     cls = cpuba_pkg::CL_NOP;
      endcase
    end
  end

  // Length, base cycle count and whether a taken branch adds a cycle
  always_comb begin
    len  = cpuba_pkg::LEN_1;
    base = cpuba_pkg::CYC_1;
    cond = 1'b0;
    case (cls)
      cpuba_pkg::CL_PAGE_JUMP, cpuba_pkg::CL_PAGE_CALL, cpuba_pkg::CL_SHORT_JUMP: begin
        len  = cpuba_pkg::LEN_2;
        base = cpuba_pkg::CYC_3;
      end
      cpuba_pkg::CL_INDEX_JUMP, cpuba_pkg::CL_EXT_MOVE: begin
        base = cpuba_pkg::CYC_3;
      end
      cpuba_pkg::CL_CARRY_SET_JMP, cpuba_pkg::CL_CARRY_CLR_JMP, cpuba_pkg::CL_DEC_JUMP: begin
        len  = cpuba_pkg::LEN_2;
        base = cpuba_pkg::CYC_2;
        cond = 1'b1;
      end
      cpuba_pkg::CL_BIT_SET_JMP, cpuba_pkg::CL_BIT_CLR_JMP, cpuba_pkg::CL_BIT_SETCLR: begin
        len  = cpuba_pkg::LEN_3;
        base = cpuba_pkg::CYC_3;
        cond = 1'b1;
      end
      cpuba_pkg::CL_CMP_IND: begin
        len  = cpuba_pkg::LEN_3;
        base = cpuba_pkg::CYC_4;
        cond = 1'b1;
      end
      cpuba_pkg::CL_AND_NOT_BIT, cpuba_pkg::CL_OR_NOT_BIT, cpuba_pkg::CL_SET_BIT,
      cpuba_pkg::CL_CLR_BIT, cpuba_pkg::CL_PUSH, cpuba_pkg::CL_MOV_IND_IMM: begin
        len  = cpuba_pkg::LEN_2;
        base = cpuba_pkg::CYC_2;
      end
      cpuba_pkg::CL_MOV_DIR_IMM: begin
        len  = cpuba_pkg::LEN_3;
        base = cpuba_pkg::CYC_3;
      end
      default: begin
        len  = cpuba_pkg::LEN_1;
        base = cpuba_pkg::CYC_1;
      end
    endcase
  end

  // Operand addressing
  assign bank_base = {3'h0, status_word_ff[cpuba_pkg::BANK_HIGH_POS],
                      status_word_ff[cpuba_pkg::BANK_LOW_POS], 3'h0};
  assign rn_addr   = bank_base | {5'h00, cur_op[2:0]};
  assign ri_addr   = bank_base | {7'h00, cur_op[0]};
  assign bit_byte  = byte1[cpuba_pkg::SFR_SPACE_POS] ? {byte1[7:3], 3'h0}
                   : cpuba_pkg::BIT_AREA_BASE + {4'h0, byte1[6:3]};
  assign bit_pos   = byte1[2:0];
  assign bit_mask  = 8'h01 << bit_pos;
  assign is_bit_op = cls == cpuba_pkg::CL_BIT_SET_JMP || cls == cpuba_pkg::CL_BIT_CLR_JMP
                  || cls == cpuba_pkg::CL_BIT_SETCLR || cls == cpuba_pkg::CL_AND_NOT_BIT
                  || cls == cpuba_pkg::CL_OR_NOT_BIT || cls == cpuba_pkg::CL_SET_BIT
                  || cls == cpuba_pkg::CL_CLR_BIT;
  assign dir_addr  = is_bit_op ? bit_byte : byte1;
  assign is_ind    = cls == cpuba_pkg::CL_CMP_IND || cls == cpuba_pkg::CL_MOV_IND_IMM;
  assign rd_b_addr = (cls == cpuba_pkg::CL_DEC_JUMP) ? rn_addr : ri_addr;
  assign rd_a_addr = is_ind ? rd_b_data : dir_addr;

  assign sfr_val = (dir_addr == cpuba_pkg::SFR_STACK_POINTER)   ? stack_pointer_ff
                 : (dir_addr == cpuba_pkg::SFR_DATA_PTR_LOW)    ? data_pointer_low_ff
                 : (dir_addr == cpuba_pkg::SFR_DATA_PTR_HIGH)   ? data_pointer_high_ff
                 : (dir_addr == cpuba_pkg::SFR_CODE_STORE_CTRL) ? code_store_control_ff
                 : (dir_addr == cpuba_pkg::SFR_STATUS_WORD)     ? status_word_ff
                 : (dir_addr == cpuba_pkg::SFR_ARITH_MAIN)      ? arith_main_operand_ff
                 : (dir_addr == cpuba_pkg::SFR_MUL_DIV_AUX)     ? mul_div_aux_operand_ff
                 : 8'h00;
  assign dir_val = dir_addr[cpuba_pkg::SFR_SPACE_POS] ? sfr_val : rd_a_data;
  assign bit_val = |(dir_val & bit_mask);
  assign carry   = status_word_ff[cpuba_pkg::CARRY_POS];
  assign dec_val = rd_b_data - 8'h01;

  always_comb begin
    case (cls)
      cpuba_pkg::CL_CARRY_SET_JMP: taken = carry;
      cpuba_pkg::CL_CARRY_CLR_JMP: taken = !carry;
      cpuba_pkg::CL_BIT_SET_JMP:   taken = bit_val;
      cpuba_pkg::CL_BIT_CLR_JMP:   taken = !bit_val;
      cpuba_pkg::CL_BIT_SETCLR:    taken = bit_val;
      cpuba_pkg::CL_CMP_IND:       taken = rd_a_data != byte1;
      cpuba_pkg::CL_DEC_JUMP:      taken = dec_val != 8'h00;
      default:                     taken = 1'b0;
    endcase
  end

  // Branch targets
  assign rel_byte = (cls == cpuba_pkg::CL_CARRY_SET_JMP || cls == cpuba_pkg::CL_CARRY_CLR_JMP
                  || cls == cpuba_pkg::CL_DEC_JUMP || cls == cpuba_pkg::CL_SHORT_JUMP)
                  ? byte1 : byte2;
  assign seq_pc   = pc_ff + {13'h0000, len};
  assign rel_pc   = seq_pc + {{8{rel_byte[7]}}, rel_byte};
  assign page_pc  = {seq_pc[15:11], cur_op[7:5], byte1};
  assign data_ptr = {data_pointer_high_ff, data_pointer_low_ff};
  assign index_pc = data_ptr + {8'h00, arith_main_operand_ff};

  always_comb begin
    case (cls)
      cpuba_pkg::CL_PAGE_JUMP, cpuba_pkg::CL_PAGE_CALL: nxt_pc = page_pc;
      cpuba_pkg::CL_INDEX_JUMP:                         nxt_pc = index_pc;
      cpuba_pkg::CL_SHORT_JUMP:                         nxt_pc = rel_pc;
      default:                                          nxt_pc = (cond && taken) ? rel_pc : seq_pc;
    endcase
  end

  // Ends one step early unless a conditional branch is taken
  assign last = (step_ff == base - 3'd1 && !(cond && taken)) || (step_ff == base);

  // Write side effects, all committed in the last cycle
  assign is_call    = cls == cpuba_pkg::CL_PAGE_CALL;
  assign is_push    = cls == cpuba_pkg::CL_PUSH;
  assign sp_inc1    = stack_pointer_ff + 8'h01;
  assign sp_inc2    = stack_pointer_ff + 8'h02;
  assign dir_wr_en  = last && ((cls == cpuba_pkg::CL_BIT_SETCLR && taken)
                   || cls == cpuba_pkg::CL_SET_BIT || cls == cpuba_pkg::CL_CLR_BIT
                   || cls == cpuba_pkg::CL_MOV_DIR_IMM);
  assign dir_wr_val = (cls == cpuba_pkg::CL_MOV_DIR_IMM) ? byte2
                    : (cls == cpuba_pkg::CL_SET_BIT) ? (dir_val | bit_mask)
                    : (dir_val & ~bit_mask);
  assign sfr_we     = dir_wr_en && dir_addr[cpuba_pkg::SFR_SPACE_POS];

  assign ram_wa.en   = (dir_wr_en && !dir_addr[cpuba_pkg::SFR_SPACE_POS])
                    || (last && (is_push || is_call || cls == cpuba_pkg::CL_MOV_IND_IMM));
  assign ram_wa.addr = (is_push || is_call) ? sp_inc1
                     : (cls == cpuba_pkg::CL_MOV_IND_IMM) ? rd_b_data : dir_addr;
  assign ram_wa.data = is_push ? dir_val
                     : is_call ? seq_pc[7:0]
                     : (cls == cpuba_pkg::CL_MOV_IND_IMM) ? byte1 : dir_wr_val;
  assign ram_wb.en   = last && (is_call || cls == cpuba_pkg::CL_DEC_JUMP);
  assign ram_wb.addr = is_call ? sp_inc2 : rn_addr;
  assign ram_wb.data = is_call ? seq_pc[15:8] : dec_val;

  assign ext_go   = last && cls == cpuba_pkg::CL_EXT_MOVE;
  assign code_sel = code_store_control_ff[cpuba_pkg::CODE_WR_EN_POS];
  assign code_bad = data_ptr > cpuba_pkg::CODE_TOP;

  cpuba_data_ram u_ram (
    .sys_clk   (sys_clk),
    .rd_a_addr (rd_a_addr),
    .rd_b_addr (rd_b_addr),
    .rd_a_data (rd_a_data),
    .rd_b_data (rd_b_data),
    .wr_a      (ram_wa),
    .wr_b      (ram_wb)
  );

  // Sequencing
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pc_ff        <= cpuba_pkg::RST_PC;
      code_addr_ff <= cpuba_pkg::RST_PC;
      step_ff      <= 3'd0;
      op_ff        <= 8'h00;
      b1_ff        <= 8'h00;
      b2_ff        <= 8'h00;
    end else begin
      pc_ff        <= last ? nxt_pc : pc_ff;
      code_addr_ff <= last ? nxt_pc : pc_ff + {13'h0000, step_ff + 3'd1};
      step_ff      <= last ? 3'd0 : step_ff + 3'd1;
      op_ff        <= (step_ff == 3'd0) ? code_rdata : op_ff;
      b1_ff        <= (step_ff == 3'd1) ? code_rdata : b1_ff;
      b2_ff        <= (step_ff == 3'd2) ? code_rdata : b2_ff;
    end
  end

  // Special function registers; unoccupied addresses ignore writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stack_pointer_ff       <= cpuba_pkg::RST_STACK_POINTER;
      data_pointer_low_ff    <= cpuba_pkg::RST_DATA_PTR;
      data_pointer_high_ff   <= cpuba_pkg::RST_DATA_PTR;
      code_store_control_ff  <= cpuba_pkg::RST_CODE_STORE_CTRL;
      status_word_ff         <= cpuba_pkg::RST_STATUS_WORD;
      arith_main_operand_ff  <= cpuba_pkg::RST_ARITH_MAIN;
      mul_div_aux_operand_ff <= cpuba_pkg::RST_MUL_DIV_AUX;
    end else begin
      if (sfr_we) begin
        case (dir_addr)
          cpuba_pkg::SFR_STACK_POINTER:   stack_pointer_ff       <= dir_wr_val;
          cpuba_pkg::SFR_DATA_PTR_LOW:    data_pointer_low_ff    <= dir_wr_val;
          cpuba_pkg::SFR_DATA_PTR_HIGH:   data_pointer_high_ff   <= dir_wr_val;
          cpuba_pkg::SFR_CODE_STORE_CTRL: code_store_control_ff  <= dir_wr_val;
          cpuba_pkg::SFR_STATUS_WORD:     status_word_ff         <= dir_wr_val;
          cpuba_pkg::SFR_ARITH_MAIN:      arith_main_operand_ff  <= dir_wr_val;
          cpuba_pkg::SFR_MUL_DIV_AUX:     mul_div_aux_operand_ff <= dir_wr_val;
          default: ;
        endcase
      end
      if (last && is_push) begin
        stack_pointer_ff <= sp_inc1;
      end
      if (last && is_call) begin
        stack_pointer_ff <= sp_inc2;
      end
      if (last && cls == cpuba_pkg::CL_AND_NOT_BIT) begin
        status_word_ff[cpuba_pkg::CARRY_POS] <= carry & !bit_val;
      end
      if (last && cls == cpuba_pkg::CL_OR_NOT_BIT) begin
        status_word_ff[cpuba_pkg::CARRY_POS] <= carry | !bit_val;
      end
    end
  end

  // External write strobes and status pulses
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      code_wr_ff      <= '0;
      xdata_wr_ff     <= '0;
      retire_ff       <= 1'b0;
      branch_taken_ff <= 1'b0;
      reserved_ff     <= 1'b0;
    end else begin
      code_wr_ff.en     <= ext_go && code_sel && !code_bad;
      code_wr_ff.addr   <= data_ptr;
      code_wr_ff.data   <= arith_main_operand_ff;
      xdata_wr_ff.en    <= ext_go && !code_sel;
      xdata_wr_ff.addr  <= data_ptr;
      xdata_wr_ff.data  <= arith_main_operand_ff;
      retire_ff         <= last;
      branch_taken_ff   <= last && (nxt_pc != seq_pc || (cond && taken));
      reserved_ff       <= (ext_go && code_sel && code_bad)
                        || (step_ff == 3'd0 && pc_ff > cpuba_pkg::CODE_TOP);
    end
  end

endmodule

// ### testbench/cpuba_core_properties.sv
// Concurrent checks on the branch and addressing core ports
module cpuba_core_properties (
  input wire logic                     sys_clk,
  input wire logic                     srst,
  input wire logic [7:0]               code_rdata,
  input wire logic [15:0]              code_addr_ff,
  input wire cpuba_pkg::cpuba_ext_wr_t code_wr_ff,
  input wire cpuba_pkg::cpuba_ext_wr_t xdata_wr_ff,
  input wire logic                     retire_ff,
  input wire logic                     branch_taken_ff,
  input wire logic                     reserved_ff,
  input wire logic [7:0]               stack_pointer_ff,
  input wire logic [7:0]               status_word_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire start_carry_set = retire_ff && code_rdata == cpuba_pkg::OP_CARRY_SET_JMP;
  sequence s_retire_in2;
    !retire_ff ##1 retire_ff;
  endsequence
  sequence s_retire_in3;
    !retire_ff [*2] ##1 retire_ff;
  endsequence
  property p_reset_values;
    disable iff (1'b0) srst |=> stack_pointer_ff == 8'h07 && status_word_ff == 8'h00 && !retire_ff;
  endproperty
  a_reset_stack_status: assert property (p_reset_values) else $error("reset values wrong");
  a_taken_with_retire: assert property (branch_taken_ff |-> retire_ff) else $error("taken without retire");
  a_code_write_bound: assert property (code_wr_ff.en |-> code_wr_ff.addr <= 16'h3dff && retire_ff)
    else $error("code write outside store");
  a_data_write_pulse: assert property (xdata_wr_ff.en |-> !code_wr_ff.en && retire_ff ##1 !xdata_wr_ff.en)
    else $error("data write strobe wrong");
  a_spare_as_nop: assert property (retire_ff && code_rdata == cpuba_pkg::OP_SPARE |=>
    retire_ff && !branch_taken_ff && code_addr_ff == $past(code_addr_ff) + 16'h1) else $error("spare opcode not nop");
  a_carry_not_taken: assert property (start_carry_set && !status_word_ff[7] |=>
    s_retire_in2 ##0 !branch_taken_ff) else $error("carry jump not taken count");
  a_carry_taken: assert property (start_carry_set && status_word_ff[7] |=>
    s_retire_in3 ##0 branch_taken_ff) else $error("carry jump taken count");
  a_index_jump_time: assert property (retire_ff && code_rdata == cpuba_pkg::OP_INDEX_JUMP |=>
    s_retire_in3 ##0 branch_taken_ff) else $error("indexed jump count");
  a_push_increments: assert property (retire_ff && code_rdata == cpuba_pkg::OP_PUSH |->
    ##2 (retire_ff && stack_pointer_ff == $past(stack_pointer_ff, 2) + 8'h1)) else $error("push pointer wrong");
endmodule
bind cpuba_core cpuba_core_properties i_props (.sys_clk(sys_clk), .srst(srst), .code_rdata(code_rdata),
  .code_addr_ff(code_addr_ff), .code_wr_ff(code_wr_ff), .xdata_wr_ff(xdata_wr_ff), .retire_ff(retire_ff),
  .branch_taken_ff(branch_taken_ff), .reserved_ff(reserved_ff), .stack_pointer_ff(stack_pointer_ff),
  .status_word_ff(status_word_ff));

// ### testbench/cpu_branch_and_memory_addressing_tb.sv
// Program-driven bench for the branch and addressing core
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module cpu_branch_and_memory_addressing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk;
  logic                     srst;
  logic [7:0]               rom [0:65535];
  logic [15:0]              code_addr_ff;
  cpuba_pkg::cpuba_ext_wr_t code_wr_ff;
  cpuba_pkg::cpuba_ext_wr_t xdata_wr_ff;
  logic                     retire_ff;
  logic                     branch_taken_ff;
  logic                     reserved_ff;
  logic [7:0]               stack_pointer_ff;
  logic [7:0]               status_word_ff;
  int                       bad_count;
  int                       n_checks;
  localparam logic [0:39][7:0] IMG = {8'h00, 8'h75, 8'hd0, 8'h18, 8'hc0, 8'h81, 8'h40, 8'h05, 8'hd2, 8'hd7,
    8'h40, 8'h02, 8'h00, 8'h00, 8'ha5, 8'h75, 8'h82, 8'h00, 8'h75, 8'h83, 8'h3e, 8'h75, 8'he0, 8'h5a, 8'hf0,
    8'h75, 8'h8f, 8'h01, 8'hf0, 8'h75, 8'h83, 8'h01, 8'hf0, 8'h80, 8'h03, 8'h73, 8'h00, 8'h00, 8'h80, 8'hfb};
  // Tail at 0x0530: push, bank register loop, indirect upper RAM, compares, bit jumps, carry logic
  localparam logic [0:33][7:0] TAIL = {8'hc0, 8'h81, 8'h75, 8'h18, 8'h02, 8'hd8, 8'hfe, 8'h75, 8'h19, 8'h81, 8'h77,
    8'h3c, 8'hb7, 8'h3c, 8'h02, 8'hb7, 8'h3d, 8'h02, 8'h00, 8'h00, 8'hd2, 8'h0b, 8'h10, 8'h0b, 8'h02, 8'h00,
    8'h00, 8'h20, 8'h0b, 8'h02, 8'hb0, 8'hd7, 8'ha0, 8'h0b};
  cpuba_core i_dut (.sys_clk(sys_clk), .srst(srst), .code_rdata(rom[code_addr_ff]), .code_addr_ff(code_addr_ff),
    .code_wr_ff(code_wr_ff), .xdata_wr_ff(xdata_wr_ff), .retire_ff(retire_ff), .branch_taken_ff(branch_taken_ff),
    .reserved_ff(reserved_ff), .stack_pointer_ff(stack_pointer_ff), .status_word_ff(status_word_ff));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Waits for one retire; checks cycle count, next pc, flags and write strobe
  task automatic step(input int c, input logic [15:0] pc, input logic [3:0] f, input logic [15:0] wa);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (retire_ff !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
    if (c != 0) `CHK(n, c)
    `CHK(code_addr_ff, pc)
    `CHK({branch_taken_ff, xdata_wr_ff.en, code_wr_ff.en, reserved_ff}, f)
    if (f[2]) `CHK({xdata_wr_ff.addr, xdata_wr_ff.data}, {wa, 8'h5a})
    if (f[1]) `CHK({code_wr_ff.addr, code_wr_ff.data}, {wa, 8'h5a})
  endtask
  initial begin
    bad_count = 0;
    n_checks = 0;
    srst = 1'b1;
    for (int i = 0; i < 65536; i++) rom[i] = 8'h00;
    for (int i = 0; i < 40; i++) rom[i] = IMG[i];
    rom[16'h015a] = 8'ha1;
    rom[16'h015b] = 8'h30;
    for (int i = 0; i < 34; i++) rom[16'h0530 + i] = TAIL[i];
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    `CHK({stack_pointer_ff, status_word_ff}, 16'h0700)
    step(0, 16'h0001, 4'h0, 16'h0);
    step(3, 16'h0004, 4'h0, 16'h0);
    step(2, 16'h0006, 4'h0, 16'h0);
    `CHK({stack_pointer_ff, status_word_ff}, 16'h0818)
    step(2, 16'h0008, 4'h0, 16'h0);
    step(2, 16'h000a, 4'h0, 16'h0);
    step(3, 16'h000e, 4'h8, 16'h0);
    `CHK(status_word_ff, 8'h98)
    step(1, 16'h000f, 4'h0, 16'h0);
    step(3, 16'h0012, 4'h0, 16'h0);
    step(3, 16'h0015, 4'h0, 16'h0);
    step(3, 16'h0018, 4'h0, 16'h0);
    step(3, 16'h0019, 4'h4, 16'h3e00);
    step(3, 16'h001c, 4'h0, 16'h0);
    step(3, 16'h001d, 4'h1, 16'h0);
    step(3, 16'h0020, 4'h0, 16'h0);
    step(3, 16'h0021, 4'h2, 16'h0100);
    step(3, 16'h0026, 4'h8, 16'h0);
    step(3, 16'h0023, 4'h8, 16'h0);
    step(3, 16'h015a, 4'h8, 16'h0);
    step(3, 16'h0530, 4'h8, 16'h0);
    step(2, 16'h0532, 4'h0, 16'h0);
    `CHK(stack_pointer_ff, 8'h09)
    step(3, 16'h0535, 4'h0, 16'h0);
    step(3, 16'h0535, 4'h8, 16'h0);
    step(2, 16'h0537, 4'h0, 16'h0);
    step(3, 16'h053a, 4'h0, 16'h0);
    step(2, 16'h053c, 4'h0, 16'h0);
    `CHK(stack_pointer_ff, 8'h09)
    step(4, 16'h053f, 4'h0, 16'h0);
    step(5, 16'h0544, 4'h8, 16'h0);
    step(2, 16'h0546, 4'h0, 16'h0);
    step(4, 16'h054b, 4'h8, 16'h0);
    step(3, 16'h054e, 4'h0, 16'h0);
    step(2, 16'h0550, 4'h0, 16'h0);
    `CHK(status_word_ff, 8'h18)
    step(2, 16'h0552, 4'h0, 16'h0);
    `CHK(status_word_ff, 8'h98)
    conclude();
  end
endmodule
